// File: midc_pkg.sv
// shared constants, types and state records for the instruction decoder
package midc_pkg;
  // word and field geometry
  localparam int IW = 14;
  localparam int QPH = 4;
  localparam int QPH_W = 2;
  localparam int CLS_LSB = 12;
  localparam int OP6_LSB = 8;
  localparam int OP4_LSB = 10;
  localparam int OP3_LSB = 11;
  localparam int OP5_LSB = 9;
  localparam int OP7_LSB = 7;
  localparam int DST_BIT = 7;
  localparam int FA_W = 7;
  localparam int BN_LSB = 7;
  localparam int BN_W = 3;
  localparam int K8_W = 8;
  localparam int K11_W = 11;
  localparam int K7_W = 7;
  localparam int K5_W = 5;
  localparam int K9_W = 9;
  localparam int OFF_W = 6;
  localparam int PS_OFF_BIT = 6;
  localparam int PS_INC_BIT = 2;
  localparam int MODE_W = 2;
  localparam int SEL_LSB = 4;
  localparam int BNK_LSB = 5;
  // reset value of the quarter-cycle phase
  localparam logic [1:0] PH_RST = 2'h0;
  localparam logic [1:0] PH_LAST = 2'h3;
  // file addresses of the two indirect access locations
  localparam logic [6:0] FA_IND0 = 7'h00;
  localparam logic [6:0] FA_IND1 = 7'h01;
  // top two bits sort the word into its format family
  localparam logic [1:0] TOP_BYTE = 2'h0;
  localparam logic [1:0] TOP_BIT = 2'h1;
  localparam logic [1:0] TOP_JMP = 2'h2;
  localparam logic [1:0] TOP_LIT = 2'h3;
  // opcode values
  localparam logic [5:0] OP_CTRL = 6'h00;
  localparam logic [5:0] OP_CLR = 6'h01;
  localparam logic [5:0] OP_DECSZ = 6'h0b;
  localparam logic [5:0] OP_INCSZ = 6'h0f;
  localparam logic [5:0] OP_LSL = 6'h35;
  localparam logic [5:0] OP_LSR = 6'h36;
  localparam logic [5:0] OP_ASR = 6'h37;
  localparam logic [5:0] OP_SUBB = 6'h3b;
  localparam logic [5:0] OP_ADDC = 6'h3d;
  localparam logic [5:0] OP_RETLIT = 6'h34;
  localparam logic [3:0] OP_BTSC = 4'h6;
  localparam logic [3:0] OP_BTSS = 4'h7;
  localparam logic [4:0] OP_RJMP = 5'h19;
  localparam logic [6:0] OP_PAGE = 7'h63;
  localparam logic [6:0] OP_PADD = 7'h62;
  localparam logic [6:0] OP_PRD = 7'h7e;
  localparam logic [6:0] OP_PWR = 7'h7f;
  localparam logic [6:0] LO_RET = 7'h08;
  localparam logic [6:0] LO_RETI = 7'h09;
  localparam logic [6:0] LO_CALLA = 7'h0a;
  localparam logic [6:0] LO_RJMPA = 7'h0b;
  localparam logic [1:0] SEL_BANK = 2'h1;
  localparam logic [2:0] SEL_PINC = 3'h1;

  // instruction format family
  typedef enum logic [1:0] {
    CL_BYTE = 2'h0,
    CL_BIT = 2'h1,
    CL_LITCTL = 2'h2
  } midc_cls_t;

  // decoded operation kind
  typedef enum logic [4:0] {
    K_CTRL, K_BYTE, K_BYTE_SKIP, K_BIT, K_BIT_SKIP, K_LIT, K_PAGE, K_BANK,
    K_RJMP, K_RJMPA, K_CALL, K_CALLA, K_JMP, K_RET, K_RETLIT, K_RETI,
    K_PTR_OFF, K_PTR_IDX, K_PTR_INC
  } midc_kind_t;

  // one-hot sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_IND = 4'b0100,
    ST_NOP = 4'b1000
  } midc_st_t;

  // all fields of one decoded word
  typedef struct packed {
    midc_kind_t kind;
    midc_cls_t cls;
    logic dst_f;
    logic [6:0] fa;
    logic [2:0] bitn;
    logic [7:0] k8;
    logic [10:0] k11;
    logic [6:0] k7;
    logic [4:0] k5;
    logic [8:0] k9;
    logic psel;
    logic [5:0] off;
    logic [1:0] mode;
    logic rmw;
    logic two_cyc;
    logic skip;
    logic ind;
  } midc_dec_t;

  // sequencer state record
  typedef struct packed {
    midc_st_t st;
    midc_dec_t dec;
    logic flow;
    logic [1:0] cnt;
  } midc_core_t;

  // divider state record
  typedef struct packed {
    logic [1:0] ph;
    logic stb;
  } midc_div_t;
endpackage

// File: midc_qdiv.sv
// quarter-rate divider: oscillator phases and instruction-cycle strobe
`timescale 1ns/1ps
module midc_qdiv (
  input wire logic clk,
  input wire logic rstn,
  output logic [1:0] phase,
  output logic stb
);
  midc_pkg::midc_div_t s_q; // registered state
  midc_pkg::midc_div_t s_d; // next state

  // phase wraps every four clocks; strobe marks the last phase
  always_comb begin
    s_d = s_q;
    s_d.ph = s_q.ph + 2'h1;
    s_d.stb = (s_d.ph == midc_pkg::PH_LAST);
  end

  // register the whole record
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{ph: midc_pkg::PH_RST, stb: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign phase = s_q.ph;
  assign stb = s_q.stb;

  // strobe recurs exactly every four clocks
  stb_period_a: assert property (@(posedge clk) disable iff (!rstn)
    stb |=> !stb [*3] ##1 stb)
    else $error("strobe period is not four clocks");
endmodule

// File: midc_decoder.sv
// instruction word decoder and cycle sequencer for the 8-bit core
// Function
// - one 14-bit word holds opcode and operands
// - sort words into byte, bit, literal/control
// - both call forms take two cycles
// - all three return forms take two cycles
// - taken jumps and skips take two cycles
// - indirect access to program memory adds cycle
// - instruction cycle is four oscillator clocks
// - file register operands are read-modify-write
// - destination bit zero accumulator, one file
// - file address spans 0x00 to 0x7f
// - byte format: opcode, dest, file address
// - bit format: opcode, bit number, address
// - general literal is low eight bits
// - call and jump carry 11-bit target
// - page latch load takes 7-bit literal
// - bank select load takes 5-bit literal
// - relative jump takes 9-bit offset
// - pointer offset: select bit 6, 6-bit offset
// - pointer step: select bit 2, 2-bit mode
// - pointer select picks one of two
// - don't-care bits never change decoding
// - second cycle of two executes as nop
// - pointer msb set triggers the extra cycle
`timescale 1ns/1ps
module midc_decoder (
  input wire logic clk,
  input wire logic rstn,
  input wire logic fetch_valid, // word on fetch_word is present
  input wire logic [13:0] fetch_word, // program memory word
  output logic fetch_ready, // word is taken at this strobe
  input wire logic skip_true, // datapath skip condition, exec cycle
  input wire logic [1:0] ptr_msb, // top bit of each pointer register
  output midc_pkg::midc_dec_t dec, // fields of current instruction
  output logic exec_cyc, // real execute cycle in progress
  output logic ind_cyc, // extra indirect access cycle
  output logic nop_cyc, // forced nop cycle
  output logic [1:0] cyc_idx, // cycle number inside instruction
  output logic [1:0] phase, // oscillator phase in cycle
  output logic cyc_stb // last clock of each instruction cycle
);
  midc_pkg::midc_core_t s_q; // registered state
  midc_pkg::midc_core_t s_d; // next state
  logic stb; // divider strobe
  logic take; // word accepted this clock
  logic ind_need; // extra cycle owed by current instruction
  logic flow_now; // current instruction changes program flow

  // four-clock instruction cycle comes from the divider
  midc_qdiv u_div (
    .clk(clk),
    .rstn(rstn),
    .phase(phase),
    .stb(stb)
  );

  // split a word into every field; the kind says which ones matter
  function automatic midc_pkg::midc_dec_t decode(input logic [13:0] w);
    midc_pkg::midc_dec_t r;
    logic [5:0] op6;
    logic [6:0] op7;
    op6 = w[midc_pkg::OP6_LSB +: 6];
    op7 = w[midc_pkg::OP7_LSB +: 7];
    r = '0;
    // whole word decoded alone, no extension words
    r.dst_f = w[midc_pkg::DST_BIT];
    r.fa = w[midc_pkg::FA_W-1:0]; // full 0x00..0x7f range
    r.bitn = w[midc_pkg::BN_LSB +: midc_pkg::BN_W];
    r.k8 = w[midc_pkg::K8_W-1:0];
    r.k11 = w[midc_pkg::K11_W-1:0];
    r.k7 = w[midc_pkg::K7_W-1:0];
    r.k5 = w[midc_pkg::K5_W-1:0];
    r.k9 = w[midc_pkg::K9_W-1:0];
    r.off = w[midc_pkg::OFF_W-1:0];
    r.mode = w[midc_pkg::MODE_W-1:0];
    r.kind = midc_pkg::K_LIT;
    r.cls = midc_pkg::CL_LITCTL;
    case (w[midc_pkg::CLS_LSB +: 2])
      midc_pkg::TOP_BYTE: begin
        if (op6 == midc_pkg::OP_CTRL && !w[midc_pkg::DST_BIT]) begin
          // inherent control group; unused low bits ignored
          if (w[6:0] == midc_pkg::LO_RET) begin
            r.kind = midc_pkg::K_RET;
          end else if (w[6:0] == midc_pkg::LO_RETI) begin
            r.kind = midc_pkg::K_RETI;
          end else if (w[6:0] == midc_pkg::LO_CALLA) begin
            r.kind = midc_pkg::K_CALLA;
          end else if (w[6:0] == midc_pkg::LO_RJMPA) begin
            r.kind = midc_pkg::K_RJMPA;
          end else if (w[midc_pkg::BNK_LSB +: 2] == midc_pkg::SEL_BANK) begin
            r.kind = midc_pkg::K_BANK;
          end else if (w[midc_pkg::SEL_LSB +: 3] == midc_pkg::SEL_PINC) begin
            r.kind = midc_pkg::K_PTR_INC;
            r.psel = w[midc_pkg::PS_INC_BIT];
          end else begin
            r.kind = midc_pkg::K_CTRL;
          end
        end else begin
          r.cls = midc_pkg::CL_BYTE;
          r.rmw = 1'b1; // read before any store
          if (op6 == midc_pkg::OP_DECSZ || op6 == midc_pkg::OP_INCSZ) begin
            r.kind = midc_pkg::K_BYTE_SKIP;
          end else begin
            r.kind = midc_pkg::K_BYTE;
          end
        end
      end
      midc_pkg::TOP_BIT: begin
        r.cls = midc_pkg::CL_BIT;
        r.rmw = 1'b1;
        if (w[midc_pkg::OP4_LSB +: 4] == midc_pkg::OP_BTSC ||
            w[midc_pkg::OP4_LSB +: 4] == midc_pkg::OP_BTSS) begin
          r.kind = midc_pkg::K_BIT_SKIP;
        end else begin
          r.kind = midc_pkg::K_BIT;
        end
      end
      midc_pkg::TOP_JMP: begin
        // bit 11 splits call from jump, rest is target
        r.kind = w[midc_pkg::OP3_LSB] ? midc_pkg::K_JMP : midc_pkg::K_CALL;
      end
      default: begin
        // literal space also holds some byte-format operations
        if (op6 == midc_pkg::OP_LSL || op6 == midc_pkg::OP_LSR ||
            op6 == midc_pkg::OP_ASR || op6 == midc_pkg::OP_SUBB ||
            op6 == midc_pkg::OP_ADDC) begin
          r.cls = midc_pkg::CL_BYTE;
          r.rmw = 1'b1;
          r.kind = midc_pkg::K_BYTE;
        end else if (w[midc_pkg::OP5_LSB +: 5] == midc_pkg::OP_RJMP) begin
          r.kind = midc_pkg::K_RJMP;
        end else if (op6 == midc_pkg::OP_RETLIT) begin
          r.kind = midc_pkg::K_RETLIT;
        end else if (op7 == midc_pkg::OP_PAGE) begin
          r.kind = midc_pkg::K_PAGE;
        end else if (op7 == midc_pkg::OP_PADD) begin
          r.kind = midc_pkg::K_PTR_OFF;
          r.psel = w[midc_pkg::PS_OFF_BIT];
        end else if (op7 == midc_pkg::OP_PRD || op7 == midc_pkg::OP_PWR) begin
          r.kind = midc_pkg::K_PTR_IDX;
          r.psel = w[midc_pkg::PS_OFF_BIT];
        end else begin
          r.kind = midc_pkg::K_LIT;
        end
      end
    endcase
    // file operand naming an indirect location goes through its pointer
    if (r.rmw && (r.fa == midc_pkg::FA_IND0 || r.fa == midc_pkg::FA_IND1)) begin
      r.ind = 1'b1;
      r.psel = r.fa[0];
    end
    if (r.kind == midc_pkg::K_PTR_INC || r.kind == midc_pkg::K_PTR_IDX) begin
      r.ind = 1'b1;
    end
    // clear-accumulator form: low bits are don't-care, never a pointer
    if (op6 == midc_pkg::OP_CLR && !w[midc_pkg::DST_BIT]) begin
      r.ind = 1'b0;
    end
    // calls, returns and jumps always change flow
    r.two_cyc = (r.kind == midc_pkg::K_CALL) || (r.kind == midc_pkg::K_CALLA) ||
                (r.kind == midc_pkg::K_RET) || (r.kind == midc_pkg::K_RETLIT) ||
                (r.kind == midc_pkg::K_RETI) ||
                (r.kind == midc_pkg::K_JMP) || (r.kind == midc_pkg::K_RJMP) ||
                (r.kind == midc_pkg::K_RJMPA);
    r.skip = (r.kind == midc_pkg::K_BYTE_SKIP) || (r.kind == midc_pkg::K_BIT_SKIP);
    return r;
  endfunction

  // extra cycle only when the chosen pointer reaches program memory
  assign ind_need = s_q.dec.ind && ptr_msb[s_q.dec.psel];
  // flow change: fixed two-cycle kinds or a true skip
  assign flow_now = s_q.dec.two_cyc || (s_q.dec.skip && skip_true);

  // ready is a handshake term; it only counts on the strobe clock
  // kept combinational so a refusal lands in the strobe clock itself
  always_comb begin
    case (s_q.st)
      midc_pkg::ST_IDLE: fetch_ready = 1'b1;
      midc_pkg::ST_EXEC: fetch_ready = !ind_need && !flow_now;
      midc_pkg::ST_IND: fetch_ready = !s_q.flow;
      midc_pkg::ST_NOP: fetch_ready = 1'b1;
      default: fetch_ready = 1'b1;
    endcase
  end

  // the only way a word enters; every other clock ignores the fetch side
  assign take = stb && fetch_valid && fetch_ready;

  // sequencer: moves only on instruction-cycle boundaries
  always_comb begin
    s_d = s_q;
    if (stb) begin
      s_d.cnt = s_q.cnt + 2'h1;
      case (s_q.st)
        midc_pkg::ST_EXEC: begin
          // skip result and flow are latched at end of execute cycle
          s_d.flow = flow_now;
          if (ind_need) begin
            s_d.st = midc_pkg::ST_IND;
          end else if (flow_now) begin
            s_d.st = midc_pkg::ST_NOP;
          end else begin
            s_d.st = midc_pkg::ST_IDLE;
          end
        end
        midc_pkg::ST_IND: begin
          s_d.st = s_q.flow ? midc_pkg::ST_NOP : midc_pkg::ST_IDLE;
        end
        midc_pkg::ST_NOP: s_d.st = midc_pkg::ST_IDLE;
        midc_pkg::ST_IDLE: s_d.st = midc_pkg::ST_IDLE;
        default: s_d.st = midc_pkg::ST_IDLE;
      endcase
      // a taken word overrides the idle fall-back above
      if (take) begin
        s_d.st = midc_pkg::ST_EXEC;
        s_d.dec = decode(fetch_word);
        s_d.flow = 1'b0;
        s_d.cnt = 2'h0;
      end
    end
  end

  // register the whole record
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '{st: midc_pkg::ST_IDLE, dec: '0, flow: 1'b0, cnt: 2'h0};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state record; cycle strobe straight from the divider
  assign dec = s_q.dec;
  assign exec_cyc = (s_q.st == midc_pkg::ST_EXEC);
  assign ind_cyc = (s_q.st == midc_pkg::ST_IND);
  assign nop_cyc = (s_q.st == midc_pkg::ST_NOP);
  assign cyc_idx = s_q.cnt;
  assign cyc_stb = stb;

  // checks on the sequencer and field extraction
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  localparam int CYC = 4; // clocks per instruction cycle

  byte_fields_a: assert property (
    take && fetch_word[13:12] == midc_pkg::TOP_BYTE && fetch_word[13:8] != 6'h00
    |=> dec.cls == midc_pkg::CL_BYTE && dec.fa == $past(fetch_word[6:0])
        && dec.dst_f == $past(fetch_word[7]) && dec.rmw)
    else $error("byte format fields wrong");

  bit_fields_a: assert property (
    take && fetch_word[13:12] == midc_pkg::TOP_BIT
    |=> dec.bitn == $past(fetch_word[9:7]) && dec.rmw)
    else $error("bit format fields wrong");

  jump_target_a: assert property (
    take && fetch_word[13:12] == midc_pkg::TOP_JMP
    |=> dec.k11 == $past(fetch_word[10:0]) && dec.two_cyc)
    else $error("call or jump target wrong");

  exec_len_a: assert property (
    $rose(exec_cyc) |-> exec_cyc [*4] ##1 !exec_cyc || $past(take, 1))
    else $error("execute cycle not four clocks");

  flow_nop_a: assert property (
    stb && exec_cyc && dec.two_cyc && !ind_need |=> nop_cyc [*4])
    else $error("flow change did not add a nop cycle");

  skip_true_a: assert property (
    stb && exec_cyc && dec.skip && skip_true && !ind_need |=> nop_cyc)
    else $error("true skip did not add a nop cycle");

  skip_false_a: assert property (
    stb && exec_cyc && dec.skip && !skip_true && !ind_need |-> fetch_ready)
    else $error("false skip did not finish in one cycle");

  ind_extra_a: assert property (
    stb && exec_cyc && dec.ind && ptr_msb[dec.psel] |=> ind_cyc [*4])
    else $error("pointer msb set gave no extra cycle");

  nop_then_free_a: assert property (
    stb && nop_cyc |-> fetch_ready ##1 !nop_cyc)
    else $error("nop cycle did not end");

  rmw_class_a: assert property (
    exec_cyc |-> dec.rmw == (dec.cls != midc_pkg::CL_LITCTL))
    else $error("read-modify-write flag disagrees with class");

  one_cycle_a: assert property (
    stb && exec_cyc && !dec.ind && !dec.two_cyc && !dec.skip |-> fetch_ready)
    else $error("plain instruction took extra cycles");

  ready_bound_a: assert property (
    $rose(exec_cyc) |-> ##[1:12] (stb && fetch_ready))
    else $error("instruction exceeded three cycles");

  // one check per narrow literal format, pinning each field to its span
  lit_field_a: assert property (
    take && fetch_word[13:12] == midc_pkg::TOP_LIT
    |=> dec.k8 == $past(fetch_word[7:0]))
    else $error("literal field wrong");

  page_field_a: assert property (
    take && fetch_word[13:7] == midc_pkg::OP_PAGE
    |=> dec.kind == midc_pkg::K_PAGE && dec.k7 == $past(fetch_word[6:0]))
    else $error("page latch literal wrong");

  bank_field_a: assert property (
    take && fetch_word[13:5] == 9'h001
    |=> dec.kind == midc_pkg::K_BANK && dec.k5 == $past(fetch_word[4:0]))
    else $error("bank select literal wrong");

  rjmp_field_a: assert property (
    take && fetch_word[13:9] == midc_pkg::OP_RJMP
    |=> dec.two_cyc && dec.k9 == $past(fetch_word[8:0]))
    else $error("relative jump offset wrong");

  ptr_off_a: assert property (
    take && fetch_word[13:7] == midc_pkg::OP_PADD
    |=> dec.psel == $past(fetch_word[6]) && dec.off == $past(fetch_word[5:0]) && !dec.ind)
    else $error("pointer offset fields wrong");

  ptr_step_a: assert property (
    take && fetch_word[13:4] == 10'h001
    |=> dec.psel == $past(fetch_word[2]) && dec.mode == $past(fetch_word[1:0]))
    else $error("pointer step fields wrong");

  dont_care_a: assert property (
    take && fetch_word[13:2] == 12'h040 |=> !dec.ind)
    else $error("don't-care bits changed decoding");

  idx_ind_a: assert property (
    ind_cyc |-> cyc_idx == 2'h1)
    else $error("indirect cycle index wrong");

  call_c: cover property (stb && exec_cyc && dec.kind == midc_pkg::K_CALL ##[1:CYC] nop_cyc);
  skip_c: cover property (stb && exec_cyc && dec.skip && skip_true);
  ind_c: cover property (ind_cyc ##[1:CYC] nop_cyc);
  b2b_c: cover property (take ##CYC take);
endmodule

// File: midc_fetch_model.sv
// program memory and datapath model seen from the decoder's fetch side
`timescale 1ns/1ps
module midc_fetch_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic req_valid, // bench asks for a word to be offered
  input wire logic [13:0] req_word,
  input wire logic req_skip, // skip outcome for that word
  input wire logic [1:0] req_msb, // pointer top bits for that word
  input wire logic cyc_stb,
  input wire logic fetch_ready,
  input wire logic exec_cyc,
  output logic fetch_valid,
  output logic [13:0] fetch_word,
  output logic skip_true,
  output logic [1:0] ptr_msb
);
  logic [13:0] junk_q; // changes every clock while no word is offered
  logic skip_q; // skip outcome of the word now executing
  logic [1:0] msb_q; // pointer bits of the word now executing

  // latch the datapath answers on the take edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      junk_q <= 14'h3fff;
      skip_q <= 1'b0;
      msb_q <= 2'h0;
    end else begin
      junk_q <= fetch_valid ? ~req_word : ~junk_q;
      if (cyc_stb && fetch_valid && fetch_ready) begin
        skip_q <= req_skip;
        msb_q <= req_msb;
      end
    end
  end

  // bus shows junk when idle, no stale word to lean on
  assign fetch_valid = req_valid;
  assign fetch_word = req_valid ? req_word : junk_q;
  // datapath values only meaningful on the exec-end strobe
  assign skip_true = (exec_cyc && cyc_stb) ? skip_q : ~skip_q;
  assign ptr_msb = (exec_cyc && cyc_stb) ? msb_q : ~msb_q;
endmodule

// File: mcu_instruction_decoder_tb.sv
// self-checking bench for the instruction decoder
`timescale 1ns/1ps
module mcu_instruction_decoder_tb;
  typedef struct packed {
    midc_pkg::midc_kind_t kind;
    midc_pkg::midc_cls_t cls;
    logic ind;
    logic nop;
  } midc_tb_exp_t;

  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  logic [13:0] req_word = 14'h0;
  logic skip_v = 1'b0;
  logic [1:0] msb_v = 2'h0;
  logic fetch_valid, fetch_ready, skip_true, exec_cyc, ind_cyc, nop_cyc, cyc_stb;
  logic [13:0] fetch_word;
  logic [1:0] ptr_msb, cyc_idx, phase;
  midc_pkg::midc_dec_t dec;
  int num_errors = 0;
  int compares = 0;
  int takes = 0;
  int seed = 31686;
  logic have = 1'b0; // an instruction is in flight
  logic took = 1'b0; // fields are due at the next check
  logic [13:0] wq; // word in flight
  midc_tb_exp_t ex;
  logic [15:0] n_ex, n_in, n_np; // clocks seen in each cycle kind
  logic [1:0] ph_e = 2'h0; // expected oscillator phase
  logic [15:0] idx_e; // expected cycle index
  // hand-picked words and their {skip, pointer msb} stimulus
  logic [13:0] cw [25] = '{14'h0008, 14'h0009, 14'h000a, 14'h000b, 14'h2555, 14'h2aaa,
    14'h3355, 14'h34a5, 14'h31ff, 14'h3145, 14'h3f40, 14'h3f85, 14'h003f, 14'h001f,
    14'h0017, 14'h1d81, 14'h1923, 14'h0b80, 14'h0f7f, 14'h07ff, 14'h0700, 14'h3592,
    14'h13ff, 14'h0000, 14'h0101};
  logic [2:0] cx [25] = '{3'h4, 3'h0, 3'h3, 3'h4, 3'h0, 3'h3, 3'h4, 3'h0, 3'h3, 3'h3,
    3'h2, 3'h1, 3'h0, 3'h3, 3'h3, 3'h6, 3'h3, 3'h5, 3'h0, 3'h3, 3'h1, 3'h4, 3'h7, 3'h4, 3'h3};

  always #12.5 clk = ~clk;

  midc_decoder dut (.clk(clk), .rstn(rstn), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .fetch_ready(fetch_ready), .skip_true(skip_true),
    .ptr_msb(ptr_msb), .dec(dec), .exec_cyc(exec_cyc), .ind_cyc(ind_cyc),
    .nop_cyc(nop_cyc), .cyc_idx(cyc_idx), .phase(phase), .cyc_stb(cyc_stb));

  midc_fetch_model mdl (.clk(clk), .rstn(rstn), .req_valid(req_valid),
    .req_word(req_word), .req_skip(skip_v), .req_msb(msb_v), .cyc_stb(cyc_stb),
    .fetch_ready(fetch_ready), .exec_cyc(exec_cyc), .fetch_valid(fetch_valid),
    .fetch_word(fetch_word), .skip_true(skip_true), .ptr_msb(ptr_msb));

  // expected kind, family and extra cycles of one word
  function automatic midc_tb_exp_t exp_of(input logic [13:0] w, input logic s,
      input logic [1:0] m);
    midc_tb_exp_t e;
    logic two;
    e = '{midc_pkg::K_LIT, midc_pkg::CL_LITCTL, 1'b0, 1'b0};
    case (w[13:12])
      2'h0: begin
        if (w[13:7] == 7'h00) begin
          if (w[6:0] == midc_pkg::LO_RET) e.kind = midc_pkg::K_RET;
          else if (w[6:0] == midc_pkg::LO_RETI) e.kind = midc_pkg::K_RETI;
          else if (w[6:0] == midc_pkg::LO_CALLA) e.kind = midc_pkg::K_CALLA;
          else if (w[6:0] == midc_pkg::LO_RJMPA) e.kind = midc_pkg::K_RJMPA;
          else if (w[6:5] == 2'h1) e.kind = midc_pkg::K_BANK;
          else if (w[6:4] == 3'h1) e.kind = midc_pkg::K_PTR_INC;
          else e.kind = midc_pkg::K_CTRL;
        end else begin
          e.cls = midc_pkg::CL_BYTE;
          e.kind = (w[13:8] == midc_pkg::OP_DECSZ || w[13:8] == midc_pkg::OP_INCSZ) ?
            midc_pkg::K_BYTE_SKIP : midc_pkg::K_BYTE;
        end
      end
      2'h1: begin
        e.cls = midc_pkg::CL_BIT;
        e.kind = (w[13:10] == midc_pkg::OP_BTSC || w[13:10] == midc_pkg::OP_BTSS) ?
          midc_pkg::K_BIT_SKIP : midc_pkg::K_BIT;
      end
      2'h2: e.kind = w[11] ? midc_pkg::K_JMP : midc_pkg::K_CALL;
      default: begin
        if (w[13:9] == midc_pkg::OP_RJMP) e.kind = midc_pkg::K_RJMP;
        else if (w[13:7] == midc_pkg::OP_PAGE) e.kind = midc_pkg::K_PAGE;
        else if (w[13:7] == midc_pkg::OP_PADD) e.kind = midc_pkg::K_PTR_OFF;
        else if (w[13:8] == 6'h3f) e.kind = midc_pkg::K_PTR_IDX;
        else if (w[13:8] inside {midc_pkg::OP_LSL, midc_pkg::OP_LSR, midc_pkg::OP_ASR,
            midc_pkg::OP_SUBB, midc_pkg::OP_ADDC}) begin
          e.cls = midc_pkg::CL_BYTE;
          e.kind = midc_pkg::K_BYTE;
        end else if (w[13:8] == midc_pkg::OP_RETLIT) e.kind = midc_pkg::K_RETLIT;
      end
    endcase
    // indirect 0/1 or pointer forms pick the pointer; clear-accumulator low bits never do
    if (e.cls != midc_pkg::CL_LITCTL && w[6:1] == 6'h00 && w[13:7] != 7'h02) e.ind = m[w[0]];
    if (e.kind == midc_pkg::K_PTR_IDX) e.ind = m[w[6]];
    if (e.kind == midc_pkg::K_PTR_INC) e.ind = m[w[2]];
    two = e.kind inside {midc_pkg::K_CALL, midc_pkg::K_CALLA, midc_pkg::K_JMP,
      midc_pkg::K_RJMP, midc_pkg::K_RJMPA, midc_pkg::K_RET, midc_pkg::K_RETLIT,
      midc_pkg::K_RETI};
    e.nop = two || (s && e.kind inside {midc_pkg::K_BYTE_SKIP, midc_pkg::K_BIT_SKIP});
    return e;
  endfunction

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // field checks keyed on the expected kind
  task automatic chk_fields();
    chk("kind", 16'(ex.kind), 16'(dec.kind));
    chk("class", 16'(ex.cls), 16'(dec.cls));
    case (ex.kind)
      midc_pkg::K_BYTE, midc_pkg::K_BYTE_SKIP, midc_pkg::K_BIT, midc_pkg::K_BIT_SKIP: begin
        chk("file addr", 16'(wq[6:0]), 16'(dec.fa));
        chk("rmw", 16'h1, 16'(dec.rmw));
        if (ex.cls == midc_pkg::CL_BYTE) chk("dest", 16'(wq[7]), 16'(dec.dst_f));
        else chk("bit number", 16'(wq[9:7]), 16'(dec.bitn));
      end
      midc_pkg::K_LIT, midc_pkg::K_RETLIT: chk("k8", 16'(wq[7:0]), 16'(dec.k8));
      midc_pkg::K_CALL, midc_pkg::K_JMP: chk("k11", 16'(wq[10:0]), 16'(dec.k11));
      midc_pkg::K_PAGE: chk("k7", 16'(wq[6:0]), 16'(dec.k7));
      midc_pkg::K_BANK: chk("k5", 16'(wq[4:0]), 16'(dec.k5));
      midc_pkg::K_RJMP: chk("k9", 16'(wq[8:0]), 16'(dec.k9));
      midc_pkg::K_PTR_OFF, midc_pkg::K_PTR_IDX: begin
        chk("offset sel", 16'(wq[6]), 16'(dec.psel));
        chk("offset", 16'(wq[5:0]), 16'(dec.off));
      end
      midc_pkg::K_PTR_INC: begin
        chk("step sel", 16'(wq[2]), 16'(dec.psel));
        chk("step mode", 16'(wq[1:0]), 16'(dec.mode));
      end
      default: ;
    endcase
  endtask

  // monitor at the falling edge, where every output has settled
  always @(negedge clk) begin
    if (rstn) begin
      if (took) begin
        took = 1'b0;
        chk_fields();
      end
      n_ex = n_ex + 16'(exec_cyc);
      n_in = n_in + 16'(ind_cyc);
      n_np = n_np + 16'(nop_cyc);
      chk("phase", 16'(ph_e), 16'(phase));
      chk("cycle strobe", 16'(ph_e == midc_pkg::PH_LAST), 16'(cyc_stb));
      ph_e = ph_e + 2'h1;
      idx_e = (nop_cyc && ex.ind) ? 16'h2 : 16'(!exec_cyc);
      if (have) chk("cycle index", idx_e, 16'(cyc_idx));
      // instruction ends at a ready strobe: compare its cycle counts
      if (cyc_stb && fetch_ready && have) begin
        have = 1'b0;
        chk("exec clocks", 16'h4, n_ex);
        chk("ind clocks", ex.ind ? 16'h4 : 16'h0, n_in);
        chk("nop clocks", ex.nop ? 16'h4 : 16'h0, n_np);
      end
      if (cyc_stb && fetch_ready && fetch_valid) begin
        ex = exp_of(fetch_word, skip_v, msb_v);
        wq = fetch_word;
        have = 1'b1;
        took = 1'b1;
        n_ex = 16'h0;
        n_in = 16'h0;
        n_np = 16'h0;
        takes++;
      end
    end else begin
      ph_e = 2'h0;
    end
  end

  // offer one word, optionally after idle clocks, and wait for its take
  task automatic issue(input logic [13:0] w, input logic [2:0] x, input int stall);
    int t;
    int base;
    if (stall > 0) begin
      req_valid = 1'b0;
      repeat (stall) @(posedge clk);
      #2;
    end
    req_word = w;
    skip_v = x[2];
    msb_v = x[1:0];
    req_valid = 1'b1;
    base = takes;
    t = 0;
    while (takes == base && t < 64) begin
      @(posedge clk);
      t++;
    end
    if (takes == base) begin
      num_errors++;
      tally_and_finish();
    end else begin
      #2;
    end
  endtask

  initial begin
    int r;
    int t;
    repeat (5) @(posedge clk);
    chk("ready in reset", 16'h1, 16'(fetch_ready));
    chk("exec in reset", 16'h0, 16'(exec_cyc));
    #2;
    rstn = 1'b1;
    // corner words back to back, every opcode family
    for (int i = 0; i < 25; i++) issue(cw[i], cx[i], 0);
    // random words with random idle gaps
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      issue(r[13:0], r[16:14], (r[19:18] == 2'h0) ? int'(r[21:20]) + 1 : 0);
    end
    req_valid = 1'b0;
    t = 0;
    while (have && t < 64) begin
      @(posedge clk);
      t++;
    end
    if (have) num_errors++;
    tally_and_finish();
  end
endmodule
